// ---- logic/acl_pkg.sv ----
`default_nettype none
package acl_pkg;
   // ------------------------------------------------------------
   // channel and word geometry
   // ------------------------------------------------------------
   localparam int         CH_N      = 4;
   localparam int         DATA_W    = 24;
   localparam int         CMD_W     = 8;
   localparam logic [1:0] CH_LAST   = 2'h3;
   localparam logic [5:0] LEN_CMD   = 6'h08;
   localparam logic [5:0] LEN_DATA  = 6'h18;
   localparam logic [5:0] LEN_CRC16 = 6'h10;
   localparam logic [5:0] LEN_CRC32 = 6'h20;
   // ------------------------------------------------------------
   // checksum
   // ------------------------------------------------------------
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   // ------------------------------------------------------------
   // command byte: bit 0 read, bits 5:1 start address
   // ------------------------------------------------------------
   localparam int CMD_READ_BIT = 0;
   localparam int CMD_ADDR_LSB = 1;
   localparam int CMD_ADDR_MSB = 5;
   // ------------------------------------------------------------
   // register offsets and fields
   // ------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTL      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS   = 8'h04;
   localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0]  ADDR_IRQ_EN   = 8'h0C;
   localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h10;
   localparam logic [7:0]  ADDR_CRC      = 8'h14;
   localparam logic [7:0]  ADDR_RES0     = 8'h20;
   localparam int          CTL_CRC_EN    = 0;
   localparam int          CTL_CRC32     = 1;
   localparam int          CTL_LINK      = 2;
   localparam logic [2:0]  CTL_RESET     = 3'h4;
   localparam int          IRQ_N         = 2;
   localparam int          IRQ_DRDY      = 0;
   localparam int          IRQ_SEQ       = 1;
   // pin order {modulator_clock, sck, cs_n, sdi}; cs_n idles high
   localparam logic [3:0]  PIN_RESET     = 4'h2;
   typedef enum logic [2:0] {
      SPI_IDLE, SPI_CMD, SPI_WORD, SPI_CRC, SPI_IGNORE
   } acl_spi_e;
endpackage
`default_nettype wire

// ---- logic/acl_latch_crc.sv ----
// Functional notes
// RULE_01 - two-stage buffer for four channel results
// RULE_02 - stage one captures on ready, linked optionally
// RULE_03 - stage two freezes channel at read start
// RULE_04 - host must finish a word before next
// RULE_05 - host waits update delay after ready edge
// RULE_06 - host timer method still adds update delay
// RULE_07 - per-channel ready flags, zero means fresh data
// RULE_08 - ready pulse pin is the preferred sync
// RULE_09 - one enable bit turns read checksum on
// RULE_10 - checksum follows last word of each sequence
// RULE_11 - crc-16 with polynomial 0x8005
// RULE_12 - checksum sent as 16 or 32 bits
// RULE_13 - ready pulse low for half modulator period
// RULE_14 - crc cleared per sequence, fed msb first
// RULE_15 - flag zero on capture, one after read
`timescale 1ns/100ps
`default_nettype none
module acl_latch_crc
   import acl_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic [7:0]               paddr,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   output logic                          irq,
   input  wire logic [CH_N*DATA_W-1:0]   conv_data,
   input  wire logic [CH_N-1:0]          conv_ready,
   input  wire logic [CH_N-1:0]          channel_active,
   input  wire logic                     modulator_clock,
   input  wire logic                     sck,
   input  wire logic                     cs_n,
   input  wire logic                     sdi,
   output logic                          sdo,
   output logic                          sdo_oe,
   output logic                          ready_pulse_pin_n
);
   // ------------------------------------------------------------
   // pin synchronisers and edge detection
   // ------------------------------------------------------------
   logic [3:0]        pin_m_r;
   logic [3:0]        pin_s_r;
   logic [3:0]        pin_d_r;
   logic              mod_rise;
   logic              mod_fall;
   logic              sck_rise;
   logic              sck_fall;
   logic              cs_hi;
   logic              sdi_s;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_m_r <= PIN_RESET;
         pin_s_r <= PIN_RESET;
         pin_d_r <= PIN_RESET;
      end else begin
         pin_m_r <= {modulator_clock, sck, cs_n, sdi};
         pin_s_r <= pin_m_r;
         pin_d_r <= pin_s_r;
      end
   end

   assign mod_rise = pin_s_r[3] & ~pin_d_r[3];
   assign mod_fall = ~pin_s_r[3] & pin_d_r[3];
   assign sck_rise = pin_s_r[2] & ~pin_d_r[2] & ~pin_s_r[1];
   assign sck_fall = ~pin_s_r[2] & pin_d_r[2] & ~pin_s_r[1];
   assign cs_hi    = pin_s_r[1];
   assign sdi_s    = pin_s_r[0];

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   logic [2:0]        ctl_r;
   logic              apb_setup;
   logic              apb_wr;

   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & pwrite;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctl_r <= CTL_RESET;
      end else if (apb_wr && paddr == ADDR_CTL) begin
         ctl_r <= pwdata[2:0]; // see RULE_09
      end
   end

   // ------------------------------------------------------------
   // first stage: capture on the modulator clock
   // ------------------------------------------------------------
   logic [CH_N-1:0]   pend_r;
   logic [CH_N-1:0]   cap_mask;
   logic [DATA_W-1:0] res_r [CH_N];

   // linked capture waits for every active channel so the set is coherent
   always_comb begin
      cap_mask = '0;
      if (mod_rise) begin
         if (ctl_r[CTL_LINK]) begin
            if (channel_active != '0 && (pend_r & channel_active) == channel_active) begin
               cap_mask = channel_active; // see RULE_02
            end
         end else begin
            cap_mask = pend_r; // see RULE_02
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pend_r <= '0;
      end else begin
         pend_r <= (pend_r & ~cap_mask) | conv_ready;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < CH_N; i++) begin
            res_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < CH_N; i++) begin
            if (cap_mask[i]) begin
               res_r[i] <= conv_data[i*DATA_W +: DATA_W]; // see RULE_01
            end
         end
      end
   end

   // low from the capture edge to the next falling modulator edge
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ready_pulse_pin_n <= 1'b1;
      end else if (cap_mask != '0) begin
         ready_pulse_pin_n <= 1'b0; // see RULE_13 see RULE_08
      end else if (mod_fall) begin
         ready_pulse_pin_n <= 1'b1; // see RULE_13
      end
   end

   // ------------------------------------------------------------
   // serial read sequencer
   // ------------------------------------------------------------
   acl_spi_e          state_r;
   acl_spi_e          nxt_state;
   logic [5:0]        bit_cnt_r;
   logic [7:0]        cmd_r;
   logic [7:0]        cmd_full;
   logic [1:0]        ch_r;
   logic [1:0]        nxt_ch;
   logic              load_r;
   logic [5:0]        len;
   logic              last_bit;
   logic              seq_end;
   logic              crc_en;

   assign crc_en   = ctl_r[CTL_CRC_EN];
   assign cmd_full = {cmd_r[6:0], sdi_s};

   always_comb begin
      case (state_r)
         SPI_CMD:  len = LEN_CMD;
         SPI_CRC:  len = ctl_r[CTL_CRC32] ? LEN_CRC32 : LEN_CRC16; // see RULE_12
         default:  len = LEN_DATA;
      endcase
   end

   assign last_bit = sck_rise && bit_cnt_r == len - 6'h01;
   assign seq_end  = last_bit && (state_r == SPI_CRC ||
                     (state_r == SPI_WORD && ch_r == CH_LAST && !crc_en));

   always_comb begin
      nxt_state = state_r;
      nxt_ch    = ch_r;
      case (state_r)
         SPI_CMD: begin
            if (cmd_full[CMD_READ_BIT] &&
                cmd_full[CMD_ADDR_MSB:CMD_ADDR_LSB] < 5'(CH_N)) begin
               nxt_state = SPI_WORD;
               nxt_ch    = cmd_full[CMD_ADDR_LSB+1:CMD_ADDR_LSB];
            end else begin
               nxt_state = SPI_IGNORE;
            end
         end
         SPI_WORD: begin
            if (ch_r != CH_LAST) begin
               nxt_ch = ch_r + 2'h1;
            end else if (crc_en) begin
               nxt_state = SPI_CRC; // see RULE_10
            end else begin
               nxt_ch = 2'h0;
            end
         end
         SPI_CRC: begin
            nxt_state = SPI_WORD;
            nxt_ch    = 2'h0;
         end
         default: begin
            nxt_state = state_r;
         end
      endcase
   end

   // a word only advances after its last bit, so a partial read holds the set
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r   <= SPI_IDLE;
         bit_cnt_r <= 6'h00;
         ch_r      <= 2'h0;
         load_r    <= 1'b0;
         cmd_r     <= 8'h00;
      end else if (cs_hi) begin
         state_r   <= SPI_IDLE;
         bit_cnt_r <= 6'h00;
         load_r    <= 1'b0;
      end else if (state_r == SPI_IDLE) begin
         state_r <= SPI_CMD;
      end else begin
         if (sck_rise && state_r == SPI_CMD) begin
            cmd_r <= cmd_full;
         end
         if (last_bit) begin
            bit_cnt_r <= 6'h00;
            state_r   <= nxt_state; // see RULE_04
            ch_r      <= nxt_ch;
            load_r    <= 1'b1;
         end else if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 6'h01;
         end else if (sck_fall) begin
            load_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // second stage and serial output
   // ------------------------------------------------------------
   logic [31:0]       shift_r;
   logic [15:0]       crc_r;
   logic [15:0]       crc_last_r;
   logic [DATA_W-1:0] cur_res;

   assign cur_res = res_r[ch_r];

   // mode 0,0: the host samples on rising sck, data moves on falling sck
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shift_r <= 32'h0000_0000;
      end else if (sck_fall && (state_r == SPI_WORD || state_r == SPI_CRC)) begin
         if (load_r && state_r == SPI_WORD) begin
            shift_r <= {cur_res, 8'h00}; // see RULE_03
         end else if (load_r) begin
            shift_r <= {crc_r, 16'h0000}; // see RULE_12
         end else begin
            shift_r <= {shift_r[30:0], 1'b0};
         end
      end
   end

   assign sdo    = shift_r[31];
   assign sdo_oe = ~cs_hi & (state_r == SPI_WORD || state_r == SPI_CRC);

   logic              crc_clr;
   logic              crc_fb;

   assign crc_clr = cs_hi || state_r == SPI_CMD || seq_end;
   assign crc_fb  = crc_r[15] ^ shift_r[31];

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         crc_r <= CRC_INIT;
      end else if (crc_clr) begin
         crc_r <= CRC_INIT; // see RULE_14
      end else if (sck_rise && state_r == SPI_WORD) begin
         crc_r <= {crc_r[14:0], 1'b0} ^ (crc_fb ? CRC_POLY : CRC_INIT); // see RULE_11
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         crc_last_r <= CRC_INIT;
      end else if (sck_fall && load_r && state_r == SPI_CRC) begin
         crc_last_r <= crc_r;
      end
   end

   // ------------------------------------------------------------
   // ready flags: capture wins over a read finishing in the same cycle
   // ------------------------------------------------------------
   logic [CH_N-1:0]   flags_r;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flags_r <= '1;
      end else begin
         for (int i = 0; i < CH_N; i++) begin
            if (cap_mask[i]) begin
               flags_r[i] <= 1'b0; // see RULE_15 see RULE_07
            end else if (last_bit && state_r == SPI_WORD && ch_r == 2'(i)) begin
               flags_r[i] <= 1'b1; // see RULE_15
            end
         end
      end
   end

   // ------------------------------------------------------------
   // interrupts and register read-back
   // ------------------------------------------------------------
   logic [IRQ_N-1:0]  irq_stat_r;
   logic [IRQ_N-1:0]  irq_en_r;
   logic [IRQ_N-1:0]  irq_ev;
   logic [IRQ_N-1:0]  irq_clr;
   logic [31:0]       prdata_r;
   logic              err_r;

   assign irq_ev  = {seq_end, cap_mask != '0};
   assign irq_clr = (apb_wr && paddr == ADDR_IRQ_CLR) ? pwdata[IRQ_N-1:0] : '0;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_en_r <= '0;
      end else if (apb_wr && paddr == ADDR_IRQ_EN) begin
         irq_en_r <= pwdata[IRQ_N-1:0];
      end
   end

   assign irq = |(irq_stat_r & irq_en_r);

   // read data is latched in the setup cycle, so every access takes two cycles, setup and access, with no wait state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata_r <= 32'h0000_0000;
         err_r    <= 1'b0;
      end else if (apb_setup) begin
         prdata_r <= 32'h0000_0000;
         err_r    <= 1'b0;
         case (paddr)
            ADDR_CTL:      prdata_r[2:0] <= ctl_r;
            ADDR_STATUS:   prdata_r[5:0] <= {sdo_oe, ready_pulse_pin_n, flags_r};
            ADDR_IRQ_STAT: prdata_r[IRQ_N-1:0] <= irq_stat_r;
            ADDR_IRQ_EN:   prdata_r[IRQ_N-1:0] <= irq_en_r;
            ADDR_IRQ_CLR:  prdata_r <= 32'h0000_0000;
            ADDR_CRC:      prdata_r[15:0] <= crc_last_r;
            ADDR_RES0, ADDR_RES0 + 8'h04, ADDR_RES0 + 8'h08, ADDR_RES0 + 8'h0C: begin
               prdata_r[DATA_W-1:0] <= res_r[paddr[3:2]];
            end
            default:       err_r <= 1'b1;
         endcase
      end
   end

   assign prdata  = prdata_r;
   assign pready  = psel & penable;
   assign pslverr = psel & penable & err_r;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_stage_one_load: assert property (cap_mask[0] |=> res_r[0] == $past(conv_data[DATA_W-1:0])) // see RULE_01
      else $error("stage one missed channel 0 result");
   a_link_all_active: assert property (ctl_r[CTL_LINK] && cap_mask != '0 |-> cap_mask == channel_active) // see RULE_02
      else $error("linked capture not whole active set");
   a_capture_on_tick: assert property (cap_mask != '0 |-> mod_rise) // see RULE_02
      else $error("capture away from modulator edge");
   a_word_frozen: assert property (sck_fall && load_r && state_r == SPI_WORD |=> shift_r[31:8] == $past(cur_res)) // see RULE_03
      else $error("read word not taken from stage one");
   a_flag_cleared: assert property (cap_mask[1] |=> !flags_r[1] && !ready_pulse_pin_n) // see RULE_15
      else $error("capture did not clear flag or pulse pin");
   a_flag_returns: assert property (last_bit && state_r == SPI_WORD && ch_r == 2'h0 && !cap_mask[0] |=> flags_r[0]) // see RULE_07
      else $error("read did not set ready flag");
   a_pulse_ends: assert property (!ready_pulse_pin_n && mod_fall |=> ready_pulse_pin_n) // see RULE_13
      else $error("ready pulse outlived half period");
   a_crc_slot: assert property (last_bit && state_r == SPI_WORD && ch_r == CH_LAST && crc_en |=> state_r == SPI_CRC) // see RULE_10
      else $error("checksum word not appended");
   a_crc_off: assert property (last_bit && state_r == SPI_WORD && ch_r == CH_LAST && !crc_en && !cs_hi |=> state_r == SPI_WORD && ch_r == 2'h0) // see RULE_09
      else $error("checksum sent while disabled");
   a_crc_poly: assert property (sck_rise && state_r == SPI_WORD && !crc_clr && crc_r == CRC_INIT && shift_r[31] |=> crc_r == CRC_POLY) // see RULE_11
      else $error("crc step wrong");
   a_crc_cleared: assert property (state_r == SPI_CMD |=> crc_r == CRC_INIT) // see RULE_14
      else $error("crc not cleared at sequence start");
   a_crc_format: assert property (sck_fall && load_r && state_r == SPI_CRC |=> shift_r == {$past(crc_r), 16'h0000}) // see RULE_12
      else $error("checksum word misformatted");

   c_linked_capture: cover property (ctl_r[CTL_LINK] && cap_mask == channel_active && cap_mask != '0);
   c_crc_sent: cover property (seq_end && state_r == SPI_CRC);
   c_irq_raised: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

// ---- bench/acl_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module acl_host_model (
   input  wire logic mclk,
   output logic      sck,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   logic got[$];
   logic last_r;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
      last_r = 1'b0;
   end
   // four mclk per half bit gives the 800 ns link period
   task automatic half();
      repeat (4) @(posedge mclk);
   endtask
   // sck stands low outside frames; sdi toggles once the command is out
   task automatic frame(input logic [7:0] cmd, input int nbits);
      logic b;
      got.delete();
      @(posedge mclk);
      cs_n <= 1'b0;
      half();
      for (int i = 0; i < 8 + nbits; i++) begin
         sdi <= (i < 8) ? cmd[7 - i] : ~sdi;
         half();
         sck <= 1'b1;
         // a released line reads as the inverse of its last level
         b = sdo_oe ? sdo : ~last_r;
         last_r = b;
         if (i >= 8) got.push_back(b);
         half();
         sck <= 1'b0;
      end
      half();
      cs_n <= 1'b1;
      half();
   endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import acl_pkg::*;
   logic                   mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic                   pready, pslverr, irq, sck, cs_n, sdi, sdo, sdo_oe, ready_pulse_pin_n;
   logic                   modulator_clock = 1'b0, erv, oe_seen = 1'b0;
   logic [7:0]             paddr = 8'h00;
   logic [31:0]            pwdata = 32'h0000_0000, prdata, rdv, seed = 32'h0001_0318;
   logic [CH_N*DATA_W-1:0] conv_data = '0;
   logic [CH_N-1:0]        conv_ready = 4'h0, channel_active = 4'hF;
   logic [23:0]            res [CH_N];
   logic [23:0]            old;
   logic [15:0]            c;
   int                     err_count = 0, check_count = 0, w;

   acl_latch_crc dut (.mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .irq, .conv_data, .conv_ready, .channel_active, .modulator_clock,
      .sck, .cs_n, .sdi, .sdo, .sdo_oe, .ready_pulse_pin_n);
   acl_host_model host (.mclk, .sck, .cs_n, .sdi, .sdo, .sdo_oe);

   always #50 mclk = ~mclk;
   // converter clock free runs at 16 mclk per period
   always #800 modulator_clock = ~modulator_clock;
   always @(posedge mclk) if (sdo_oe) oe_seen <= 1'b1;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h8020_0003 : 32'h0000_0000);
   endfunction
   function automatic logic [15:0] crc_w(input logic [15:0] r, input logic [23:0] d, input int n);
      for (int i = n - 1; i >= 0; i--) r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      return r;
   endfunction
   function automatic logic [31:0] getw(input int o, input int n);
      logic [31:0] v;
      v = 32'h0000_0000;
      for (int i = 0; i < n; i++) v = {v[30:0], host.got[o + i]};
      return v;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // a wait that runs out is counted as a mismatch here
      chk("pready", pready, 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, rdv, e);
      chk("pslverr", erv, 1'b0);
   endtask
   task automatic capture(input logic [3:0] m);
      int n;
      n = 0;
      @(posedge mclk);
      for (int i = 0; i < CH_N; i++) begin
         if (m[i]) begin
            res[i] = seed[23:0];
            seed = lfsr(seed);
            conv_data[DATA_W*i +: DATA_W] <= res[i];
         end
      end
      conv_ready <= m;
      @(posedge mclk);
      conv_ready <= 4'h0;
      while (ready_pulse_pin_n !== 1'b0 && n < 60) begin
         @(posedge mclk);
         n++;
      end
      w = 0;
      while (ready_pulse_pin_n === 1'b0 && w < 40) begin
         @(posedge mclk);
         w++;
      end
      // results are read only after the output update delay
      repeat (2) @(posedge mclk);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge mclk);
      err_count++;
      give_verdict();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk("pin_n", ready_pulse_pin_n, 1'b1);
      chk("irq", irq, 1'b0);
      chk("sdo_oe", sdo_oe, 1'b0);
      rchk("ctl", ADDR_CTL, 32'h0000_0004);
      rchk("status", ADDR_STATUS, 32'h0000_001F);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped_err", erv, 1'b1);
      chk("unmapped_data", rdv, 32'h0000_0000);
      wr(ADDR_CTL, 32'h0000_0000);
      for (int i = 0; i < CH_N; i++) begin
         capture(4'h1 << i);
         chk("pulse_w", w >= 7 && w <= 9, 1'b1);
         rchk("result", ADDR_RES0 + 8'(4 * i), {8'h00, res[i]});
      end
      rchk("status", ADDR_STATUS, 32'h0000_0010);
      rchk("irq_stat", ADDR_IRQ_STAT, 32'h0000_0001);
      chk("irq_masked", irq, 1'b0);
      wr(ADDR_IRQ_EN, 32'h0000_0003);
      @(posedge mclk);
      chk("irq_on", irq, 1'b1);
      wr(ADDR_IRQ_CLR, 32'h0000_0003);
      @(posedge mclk);
      chk("irq_off", irq, 1'b0);
      wr(ADDR_CTL, 32'h0000_0001);
      host.frame(8'h01, 4 * DATA_W + 16);
      c = CRC_INIT;
      for (int i = 0; i < CH_N; i++) begin
         chk("word", getw(24 * i, 24), {8'h00, res[i]});
         c = crc_w(c, res[i], 24);
      end
      chk("crc16", getw(96, 16), {16'h0000, c});
      rchk("crc_reg", ADDR_CRC, {16'h0000, c});
      rchk("irq_stat", ADDR_IRQ_STAT, 32'h0000_0002);
      rchk("status", ADDR_STATUS, 32'h0000_001F);
      // a new capture lands while channel two is being shifted out
      wr(ADDR_CTL, 32'h0000_0003);
      old = res[2];
      fork
         host.frame(8'h05, 2 * DATA_W + 32);
         begin
            repeat (110) @(posedge mclk);
            capture(4'h4);
         end
      join
      chk("frozen", getw(0, 24), {8'h00, old});
      chk("word", getw(24, 24), {8'h00, res[3]});
      c = crc_w(crc_w(CRC_INIT, old, 24), res[3], 24);
      chk("crc32", getw(48, 32), {c, 16'h0000});
      rchk("result", ADDR_RES0 + 8'h08, {8'h00, res[2]});
      wr(ADDR_CTL, 32'h0000_0000);
      host.frame(8'h07, 2 * DATA_W);
      chk("word", getw(0, 24), {8'h00, res[3]});
      chk("no_crc", getw(24, 24), {8'h00, res[0]});
      for (int i = 0; i < 2; i++) begin
         oe_seen <= 1'b0;
         host.frame(i ? 8'h09 : 8'h00, DATA_W);
         chk("refused_oe", oe_seen, 1'b0);
      end
      wr(ADDR_CTL, 32'h0000_0004);
      channel_active <= 4'h3;
      capture(4'h1);
      chk("linked_wait", w, 0);
      capture(4'h2);
      chk("linked_pulse", w > 0, 1'b1);
      rchk("result", ADDR_RES0, {8'h00, res[0]});
      rchk("result", ADDR_RES0 + 8'h04, {8'h00, res[1]});
      give_verdict();
   end
endmodule
`default_nettype wire
